// ===== io_map_pkg.sv
/*
  Shared constants and command types for the I/O assembly map and message store.
  Assumes it is compiled before every module that imports it.
*/
package io_map_pkg;

  // ==========================================================================
  // Word and device layout
  // ==========================================================================
  localparam int          WORD_W       = 16;
  localparam int          POINTS       = 16;
  localparam int          SLOTS        = 8;
  localparam int          SLOT_W       = 3;
  localparam int          PT_W         = 4;
  localparam int          CNT_W        = 16;
  localparam int          WIDX_W       = 8;
  localparam int          ASM_WORDS    = 228;
  localparam int          OUT_BASE     = 8;
  localparam logic [3:0]  RESV_IDX_LO  = 4'h6;
  localparam logic [3:0]  MSG_IDX      = 4'h7;
  localparam logic [3:0]  CTRL_IDX     = 4'he;
  localparam logic [3:0]  RESV_IDX_HI  = 4'hf;

  // ==========================================================================
  // Assembly instances
  // ==========================================================================
  localparam logic [7:0]  INST_IN      = 8'h64;
  localparam logic [7:0]  INST_OUT     = 8'h70;

  // ==========================================================================
  // Message register fields
  // ==========================================================================
  localparam int          CODE_HI      = 15;
  localparam int          CODE_LO      = 8;
  localparam int          DATA_HI      = 7;
  localparam int          DATA_LO      = 0;
  localparam logic [7:0]  CODE_NONE    = 8'h00;
  localparam logic [7:0]  CODE_DISABLE = 8'hfe;
  localparam logic [7:0]  DATA_NONE    = 8'h00;

  // ==========================================================================
  // Timing and size figures that bind the scanner, kept for reference by users
  // ==========================================================================
  localparam int          RPI_MIN_MS       = 50;
  localparam int          LEGACY_MAX_WORDS = 103;

  typedef enum logic [1:0] {
    CMD_CLEAR   = 2'b00,
    CMD_DISABLE = 2'b01,
    CMD_IGNORE  = 2'b10
  } msg_cmd_e;

endpackage : io_map_pkg

// ===== asm_word_mapper.sv
/*
  Finds the register that an assembly word maps to, by counting selected slots.
  Assumes a select mask of SLOTS bits per device, devices in ascending order.
*/
`timescale 1ns/1ps
module asm_word_mapper
  import io_map_pkg::*;
#(
  parameter int NUM_DEV = 4,
  parameter int DEV_W   = 2
) (
  input  wire logic [NUM_DEV*SLOTS-1:0] sel,
  input  wire logic [WIDX_W-1:0]        word,
  output logic                          hit,
  output logic      [DEV_W-1:0]         dev,
  output logic      [SLOT_W-1:0]        slot
);

  if (NUM_DEV < 1 || DEV_W < 1 || NUM_DEV > 2**DEV_W) begin : g_bad_par
    $error("asm_word_mapper: NUM_DEV does not fit in DEV_W bits");
  end

  // ==========================================================================
  // Consecutive fill from word zero
  // ==========================================================================
  logic [CNT_W-1:0] cnt;

  always_comb begin
    cnt  = '0;
    hit  = 1'b0;
    dev  = '0;
    slot = '0;
    for (int d = 0; d < NUM_DEV; d++) begin
      for (int s = 0; s < SLOTS; s++) begin
        if (sel[d*SLOTS+s]) begin
          // No word is kept for any unit: the n-th selected slot is word n.
          if (!hit && cnt == CNT_W'(word)) begin
            hit  = 1'b1;
            dev  = DEV_W'(d);
            slot = SLOT_W'(s);
          end
          cnt = cnt + 1'b1;
        end
      end
    end
  end

endmodule : asm_word_mapper

// ===== io_map_msg_store.sv
/*
  Local register bank of a wireless gateway: input and output assemblies, the
  legacy read and write tables, and one message register per device.
  Assumes all request inputs are synchronous to mclk and last one cycle.
*/
`timescale 1ns/1ps
module io_map_msg_store
  import io_map_pkg::*;
#(
  parameter int NUM_DEV = 4,
  parameter int DEV_W   = 2
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [NUM_DEV*SLOTS-1:0] eip_in_sel,
  input  wire logic [NUM_DEV*SLOTS-1:0] eip_out_sel,
  input  wire logic                     req_valid,
  input  wire logic                     req_legacy,
  input  wire logic                     req_write,
  input  wire logic [7:0]               req_inst,
  input  wire logic [WIDX_W-1:0]        req_word,
  input  wire logic [WORD_W-1:0]        req_wdata,
  output logic                          rsp_valid,
  output logic      [WORD_W-1:0]        rsp_data,
  output logic                          rsp_err,
  input  wire logic                     io_wr_valid,
  input  wire logic [DEV_W-1:0]         io_wr_dev,
  input  wire logic [PT_W-1:0]          io_wr_point,
  input  wire logic [WORD_W-1:0]        io_wr_data,
  output logic                          out_upd_valid,
  output logic      [DEV_W-1:0]         out_upd_dev,
  output logic      [PT_W-1:0]          out_upd_point,
  output logic      [WORD_W-1:0]        out_upd_data,
  input  wire logic                     msg_valid,
  input  wire logic [DEV_W-1:0]         msg_dev,
  input  wire logic [7:0]               msg_code,
  input  wire logic [7:0]               msg_data,
  input  wire logic                     heal_valid,
  input  wire logic [DEV_W-1:0]         heal_dev,
  input  wire logic                     cfg_auto_rec_wr,
  input  wire logic                     cfg_auto_rec_val,
  input  wire logic                     host_valid,
  input  wire logic [DEV_W-1:0]         host_dev,
  input  wire logic                     host_disable,
  input  wire logic                     op_ack,
  input  wire logic                     op_valid,
  input  wire msg_cmd_e                 op_cmd,
  output logic                          disp_alert,
  output logic                          disp_choice,
  output logic      [DEV_W-1:0]         disp_dev,
  output logic      [WORD_W-1:0]        disp_msg,
  output logic                          auto_rec_on
);

  if (NUM_DEV < 2 || DEV_W != $clog2(NUM_DEV) || NUM_DEV*SLOTS >= 2**CNT_W) begin : g_bad_par
    $error("io_map_msg_store: NUM_DEV and DEV_W do not agree");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [NUM_DEV-1:0][POINTS-1:0][WORD_W-1:0] regs;
    logic [NUM_DEV-1:0][WORD_W-1:0]             last_rx;
    logic                                       auto_rec;
    logic                                       rsp_valid;
    logic [WORD_W-1:0]                          rsp_data;
    logic                                       rsp_err;
    logic                                       upd_valid;
    logic [DEV_W-1:0]                           upd_dev;
    logic [PT_W-1:0]                            upd_point;
    logic [WORD_W-1:0]                          upd_data;
    logic                                       alert;
    logic                                       choice;
    logic [DEV_W-1:0]                           a_dev;
    logic [WORD_W-1:0]                          a_msg;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic              in_hit;
  logic [DEV_W-1:0]  in_dev;
  logic [SLOT_W-1:0] in_slot;
  logic              out_hit;
  logic [DEV_W-1:0]  out_dev;
  logic [SLOT_W-1:0] out_slot;

  asm_word_mapper #(.NUM_DEV(NUM_DEV), .DEV_W(DEV_W)) u_in_map (
    .sel  (eip_in_sel),
    .word (req_word),
    .hit  (in_hit),
    .dev  (in_dev),
    .slot (in_slot)
  );

  asm_word_mapper #(.NUM_DEV(NUM_DEV), .DEV_W(DEV_W)) u_out_map (
    .sel  (eip_out_sel),
    .word (req_word),
    .hit  (out_hit),
    .dev  (out_dev),
    .slot (out_slot)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic              to_in;
  logic              inst_ok;
  logic [WORD_W-1:0] m;
  logic              op_take;
  logic              new_msg;
  logic              alert_set;
  logic [DEV_W-1:0]  alert_dev;
  logic [WORD_W-1:0] alert_msg;
  logic [PT_W-1:0]   out_pt;

  always_comb begin
    st_nxt    = st_r;
    to_in     = 1'b0;
    inst_ok   = 1'b0;
    m         = '0;
    alert_set = 1'b0;
    alert_dev = '0;
    alert_msg = '0;
    out_pt    = PT_W'(OUT_BASE) + PT_W'(out_slot);
    op_take   = op_valid && st_r.choice;
    // Identical reports are only counted once per device.
    new_msg   = msg_valid && ({msg_code, msg_data} != st_r.last_rx[msg_dev]);
    st_nxt.rsp_valid = 1'b0;
    st_nxt.upd_valid = 1'b0;

    if (cfg_auto_rec_wr) begin
      st_nxt.auto_rec = cfg_auto_rec_val;
    end

    // Radio side refreshes ordinary inputs; reserved points stay with the block.
    if (io_wr_valid && io_wr_point < PT_W'(OUT_BASE) && io_wr_point != RESV_IDX_LO
        && io_wr_point != MSG_IDX) begin
      st_nxt.regs[io_wr_dev][io_wr_point] = io_wr_data;
    end

    // Assembly and legacy table access, one answer per request.
    if (req_valid) begin
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_data  = '0;
      st_nxt.rsp_err   = 1'b0;
      if (req_legacy) begin
        // Legacy read table is the input list, write table the output list.
        to_in   = !req_write;
        inst_ok = 1'b1;
      end else if (req_inst == INST_IN) begin
        to_in   = 1'b1;
        inst_ok = 1'b1;
      end else if (req_inst == INST_OUT) begin
        inst_ok = 1'b1;
      end
      if (!inst_ok || req_word >= WIDX_W'(ASM_WORDS)) begin
        st_nxt.rsp_err = 1'b1;
      end else if (to_in) begin
        if (req_write) begin
          st_nxt.rsp_err = 1'b1;
        end else if (in_hit) begin
          st_nxt.rsp_data = st_r.regs[in_dev][in_slot];
        end
      end else if (out_hit) begin
        if (req_write) begin
          st_nxt.regs[out_dev][out_pt] = req_wdata;
          st_nxt.upd_valid = 1'b1;
          st_nxt.upd_dev   = out_dev;
          st_nxt.upd_point = out_pt;
          st_nxt.upd_data  = req_wdata;
        end else begin
          st_nxt.rsp_data = st_r.regs[out_dev][out_pt];
        end
      end
      // Words past the selected count read zero and drop writes.
    end

    if (msg_valid) begin
      st_nxt.last_rx[msg_dev] = {msg_code, msg_data};
    end

    // Message registers: clears first, so an arriving message wins over them.
    for (int d = 0; d < NUM_DEV; d++) begin
      m = st_r.regs[d][MSG_IDX];
      if (host_valid && host_dev == DEV_W'(d)) begin
        m = host_disable ? {CODE_DISABLE, DATA_NONE} : '0;
      end
      if (op_take && st_r.a_dev == DEV_W'(d) && op_cmd != CMD_IGNORE) begin
        m = (op_cmd == CMD_DISABLE) ? {CODE_DISABLE, DATA_NONE} : '0;
      end
      if (heal_valid && heal_dev == DEV_W'(d) && st_r.auto_rec
          && m[CODE_HI:CODE_LO] != CODE_DISABLE) begin
        m = '0;
      end
      if (new_msg && msg_dev == DEV_W'(d)) begin
        if (m[CODE_HI:CODE_LO] == CODE_DISABLE) begin
          m = m;
        end else if (msg_code == CODE_NONE) begin
          if (m == '0) begin
            m = {msg_code, msg_data};
          end
        end else if (msg_code > m[CODE_HI:CODE_LO]) begin
          // Higher code wins; equal or lower codes are dropped.
          m[CODE_HI:CODE_LO] = msg_code;
          m[DATA_HI:DATA_LO] = msg_data;
          alert_set = 1'b1;
          alert_dev = DEV_W'(d);
          alert_msg = m;
        end
      end
      // Nothing else touches point 7, so a stored error holds until cleared.
      st_nxt.regs[d][MSG_IDX] = m;
    end

    // Display: alert, acknowledge, then one operator choice.
    if (op_ack && st_r.alert) begin
      st_nxt.alert  = 1'b0;
      st_nxt.choice = 1'b1;
    end
    if (op_take) begin
      st_nxt.choice = 1'b0;
    end
    if (alert_set) begin
      st_nxt.alert  = 1'b1;
      st_nxt.choice = 1'b0;
      st_nxt.a_dev  = alert_dev;
      st_nxt.a_msg  = alert_msg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.auto_rec <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid     = st_r.rsp_valid;
  assign rsp_data      = st_r.rsp_data;
  assign rsp_err       = st_r.rsp_err;
  assign out_upd_valid = st_r.upd_valid;
  assign out_upd_dev   = st_r.upd_dev;
  assign out_upd_point = st_r.upd_point;
  assign out_upd_data  = st_r.upd_data;
  assign disp_alert    = st_r.alert;
  assign disp_choice   = st_r.choice;
  assign disp_dev      = st_r.a_dev;
  assign disp_msg      = st_r.a_msg;
  assign auto_rec_on   = st_r.auto_rec;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [WORD_W-1:0] cur_msg;
  logic              quiet;

  assign cur_msg = st_r.regs[msg_dev][MSG_IDX];
  assign quiet   = !host_valid && !op_take && !heal_valid;

  chk_rsp_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |=> rsp_valid ##1 !rsp_valid || $past(req_valid))
    else $error("request not answered in one cycle");

  chk_unmapped_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && !req_legacy && req_inst == INST_IN && !req_write && !in_hit
     && req_word < WIDX_W'(ASM_WORDS)) |=> (rsp_data == '0 && !rsp_err))
    else $error("unmapped input word did not read zero");

  chk_disabled_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (msg_valid && cur_msg[CODE_HI:CODE_LO] == CODE_DISABLE && quiet)
    |=> st_r.regs[$past(msg_dev)][MSG_IDX] == $past(cur_msg))
    else $error("disabled message register changed");

  chk_zero_no_over: assert property (@(posedge mclk) disable iff (!rst_n)
    (msg_valid && msg_code == CODE_NONE && cur_msg != '0 && quiet)
    |=> st_r.regs[$past(msg_dev)][MSG_IDX] == $past(cur_msg))
    else $error("zero message overwrote a pending message");

  chk_lower_dropped: assert property (@(posedge mclk) disable iff (!rst_n)
    (msg_valid && msg_code != CODE_NONE && msg_code <= cur_msg[CODE_HI:CODE_LO] && quiet)
    |=> st_r.regs[$past(msg_dev)][MSG_IDX] == $past(cur_msg))
    else $error("lower priority message was stored");

  chk_higher_stored: assert property (@(posedge mclk) disable iff (!rst_n)
    (new_msg && msg_code > cur_msg[CODE_HI:CODE_LO]
     && cur_msg[CODE_HI:CODE_LO] != CODE_DISABLE && quiet)
    |=> st_r.regs[$past(msg_dev)][MSG_IDX] == {$past(msg_code), $past(msg_data)}
        && disp_alert && disp_msg == {$past(msg_code), $past(msg_data)})
    else $error("higher priority message not stored and shown");

  chk_repeat_once: assert property (@(posedge mclk) disable iff (!rst_n)
    (msg_valid && {msg_code, msg_data} == st_r.last_rx[msg_dev] && quiet)
    |=> st_r.regs[$past(msg_dev)][MSG_IDX] == $past(cur_msg) && !$rose(disp_alert))
    else $error("repeated message acted on twice");

  chk_host_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (host_valid && !host_disable && !(msg_valid && msg_dev == host_dev) && !op_take)
    |=> st_r.regs[$past(host_dev)][MSG_IDX] == '0)
    else $error("host clear did not empty the message register");

  chk_heal_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (heal_valid && auto_rec_on && st_r.regs[heal_dev][MSG_IDX][CODE_HI:CODE_LO] != CODE_DISABLE
     && !msg_valid && !host_valid && !op_take)
    |=> st_r.regs[$past(heal_dev)][MSG_IDX] == '0)
    else $error("auto recovery did not erase a healed error");

  chk_write_update: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && req_write && !req_legacy && req_inst == INST_OUT && out_hit
     && req_word < WIDX_W'(ASM_WORDS))
    |=> out_upd_valid && out_upd_data == $past(req_wdata)
        && st_r.regs[out_upd_dev][out_upd_point] == out_upd_data)
    else $error("output word write did not update its register");

endmodule : io_map_msg_store

// ===== scanner_model.sv
/*
  Behavioural model of the scanner that reads and writes the assemblies.
  Assumes the access port answers exactly one cycle after each request.
*/
`timescale 1ns/1ps
module scanner_model
  import io_map_pkg::*;
#(
  parameter int RPI_CYC = 2
) (
  input  wire logic              mclk,
  input  wire logic              rsp_valid,
  input  wire logic [WORD_W-1:0] rsp_data,
  input  wire logic              rsp_err,
  output logic                   req_valid,
  output logic                   req_legacy,
  output logic                   req_write,
  output logic      [7:0]        req_inst,
  output logic      [WIDX_W-1:0] req_word,
  output logic      [WORD_W-1:0] req_wdata
);
  // ==========================================================================
  // Requests
  // ==========================================================================
  initial begin
    req_valid  = 1'b0;
    req_legacy = 1'b0;
    req_write  = 1'b0;
    req_inst   = 8'h00;
    req_word   = 8'h00;
    req_wdata  = 16'h0000;
  end

  // Idle cycles ahead of each request stand in for the packet interval.
  // One word per request stays inside the per-instruction word limit.
  task automatic xfer(input logic leg, input logic wr, input logic [7:0] inst,
                      input logic [WIDX_W-1:0] word, input logic [WORD_W-1:0] wd,
                      output logic [WORD_W-1:0] rd, output logic err, output logic ok);
    repeat (RPI_CYC) @(posedge mclk);
    #1;
    req_valid  = 1'b1;
    req_legacy = leg;
    req_write  = wr;
    req_inst   = inst;
    req_word   = word;
    req_wdata  = wd;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req_inst  = ~inst;
    req_word  = ~word;
    req_wdata = ~wd;
    ok  = (rsp_valid === 1'b1);
    rd  = rsp_data;
    err = rsp_err;
  endtask : xfer
endmodule : scanner_model

// ===== io_register_map_and_message_store_tb_top.sv
/*
  Self-checking bench for the assembly map and message store.
  Assumes a 40 MHz clock and device 3 point 7 mapped to input word 5.
*/
`timescale 1ns/1ps
module io_register_map_and_message_store_tb_top;
  import io_map_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic mclk, rst_n, req_valid, req_legacy, req_write, rsp_valid, rsp_err;
  logic [7:0] req_inst, msg_code, msg_data;
  logic [WIDX_W-1:0] req_word;
  logic [15:0] req_wdata, rsp_data, io_wr_data, out_upd_data, disp_msg, rdat;
  logic [31:0] eip_in_sel, eip_out_sel;
  logic io_wr_valid, out_upd_valid, msg_valid, heal_valid, cfg_auto_rec_wr;
  logic cfg_auto_rec_val, host_valid, host_disable, op_ack, op_valid;
  logic disp_alert, disp_choice, auto_rec_on, rerr, rok;
  logic [1:0] io_wr_dev, out_upd_dev, disp_dev, msg_dev, heal_dev, host_dev;
  logic [3:0] io_wr_point, out_upd_point;
  msg_cmd_e op_cmd;
  int miscompares, n_checks, cycles;
  localparam logic [15:0] IN_EXP [7] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444,
                                         16'h0000, 16'h0000, 16'h0000};
  localparam logic [5:0]  OUT_DP [4] = '{6'h09, 6'h0b, 6'h18, 6'h1a};

  io_map_msg_store dut (.mclk(mclk), .rst_n(rst_n), .eip_in_sel(eip_in_sel),
    .eip_out_sel(eip_out_sel), .req_valid(req_valid), .req_legacy(req_legacy),
    .req_write(req_write), .req_inst(req_inst), .req_word(req_word),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .io_wr_valid(io_wr_valid), .io_wr_dev(io_wr_dev), .io_wr_point(io_wr_point),
    .io_wr_data(io_wr_data), .out_upd_valid(out_upd_valid), .out_upd_dev(out_upd_dev),
    .out_upd_point(out_upd_point), .out_upd_data(out_upd_data), .msg_valid(msg_valid),
    .msg_dev(msg_dev), .msg_code(msg_code), .msg_data(msg_data), .heal_valid(heal_valid),
    .heal_dev(heal_dev), .cfg_auto_rec_wr(cfg_auto_rec_wr), .cfg_auto_rec_val(cfg_auto_rec_val),
    .host_valid(host_valid), .host_dev(host_dev), .host_disable(host_disable), .op_ack(op_ack),
    .op_valid(op_valid), .op_cmd(op_cmd), .disp_alert(disp_alert),
    .disp_choice(disp_choice), .disp_dev(disp_dev), .disp_msg(disp_msg),
    .auto_rec_on(auto_rec_on));
  scanner_model scn (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_err(rsp_err), .req_valid(req_valid), .req_legacy(req_legacy),
    .req_write(req_write), .req_inst(req_inst), .req_word(req_word), .req_wdata(req_wdata));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask : chk
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic acc(input logic l, w, input logic [7:0] i, wd, input logic [15:0] d);
    scn.xfer(l, w, i, wd, d, rdat, rerr, rok);
    chk({15'h0, rok}, 16'h0001);
  endtask : acc
  task automatic rd_msg(input logic [15:0] e);
    acc(1'b0, 1'b0, INST_IN, 8'd5, 16'h0);
    chk(rdat, e);
  endtask : rd_msg
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    tick();
    {msg_valid, msg_code, msg_data} = {1'b1, c, d};
    tick();
    {msg_valid, msg_code, msg_data} = {1'b0, ~c, ~d};
  endtask : send
  task automatic io_wr(input logic [1:0] dv, input logic [3:0] p, input logic [15:0] d);
    tick();
    {io_wr_valid, io_wr_dev, io_wr_point, io_wr_data} = {1'b1, dv, p, d};
    tick();
    {io_wr_valid, io_wr_data} = {1'b0, ~d};
  endtask : io_wr
  // Kind 0 acknowledge, 1 heal, 2 host clear, 3 host disable, 4/5 recovery off/on, 6 choice.
  task automatic ev(input int k, input msg_cmd_e c = CMD_CLEAR);
    tick();
    {op_ack, heal_valid, host_valid, host_disable} = {k == 0, k == 1, k inside {2, 3}, k == 3};
    {cfg_auto_rec_wr, cfg_auto_rec_val, op_valid} = {k inside {4, 5}, k == 5, k == 6};
    op_cmd = c;
    tick();
    {op_ack, heal_valid, host_valid, cfg_auto_rec_wr, op_valid} = 5'h00;
  endtask : ev
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_inputs;
    io_wr(2'h0, 4'h0, 16'h1111);
    io_wr(2'h0, 4'h5, 16'h2222);
    io_wr(2'h1, 4'h2, 16'h3333);
    io_wr(2'h1, 4'h3, 16'h4444);
    io_wr(2'h2, 4'h6, 16'h5555);
    io_wr(2'h0, 4'h1, 16'h6666);
    for (int w = 0; w < 7; w++) begin
      acc(1'b0, 1'b0, INST_IN, 8'(w), 16'h0);
      chk(rdat, IN_EXP[w]);
      acc(1'b1, 1'b0, 8'h00, 8'(w), 16'h0);
      chk(rdat, IN_EXP[w]);
    end
  endtask : t_inputs
  task automatic t_outputs;
    for (int w = 0; w < 4; w++) begin
      acc(w[0], 1'b1, INST_OUT, 8'(w), 16'ha000 + 16'(w));
      chk({15'h0, out_upd_valid}, 16'h0001);
      chk({10'h0, out_upd_dev, out_upd_point}, {10'h0, OUT_DP[w]});
      chk(out_upd_data, 16'ha000 + 16'(w));
    end
    acc(1'b0, 1'b0, INST_OUT, 8'd2, 16'h0);
    chk(rdat, 16'ha002);
    acc(1'b0, 1'b1, INST_OUT, 8'd4, 16'hbeef);
    chk({14'h0, out_upd_valid, rerr}, 16'h0000);
    acc(1'b0, 1'b1, INST_IN, 8'd0, 16'h1);
    chk({15'h0, rerr}, 16'h0001);
    acc(1'b0, 1'b0, INST_IN, 8'd228, 16'h0);
    chk({15'h0, rerr}, 16'h0001);
    acc(1'b0, 1'b0, 8'h65, 8'd0, 16'h0);
    chk({15'h0, rerr}, 16'h0001);
    acc(1'b0, 1'b1, 8'h71, 8'd0, 16'h0);
    chk({15'h0, rerr}, 16'h0001);
  endtask : t_outputs
  task automatic t_display;
    send(8'h20, 8'h07);
    chk({disp_alert, 13'h0, disp_dev}, 16'h8003);
    chk(disp_msg, 16'h2007);
    ev(0);
    chk({14'h0, disp_alert, disp_choice}, 16'h0001);
    ev(6, CMD_IGNORE);
    chk({15'h0, disp_choice}, 16'h0000);
    send(8'h10, 8'h00);
    chk({15'h0, disp_alert}, 16'h0000);
    rd_msg(16'h2007);
    send(8'h30, 8'h01);
    chk({disp_alert, 15'h0}, 16'h8000);
    chk(disp_msg, 16'h3001);
    ev(0);
    ev(6, CMD_DISABLE);
    rd_msg(16'hfe00);
    ev(2);
    send(8'h22, 8'h00);
    ev(0);
    ev(6, CMD_CLEAR);
    rd_msg(16'h0000);
  endtask : t_display
  task automatic t_priority;
    send(8'h35, 8'h01);
    rd_msg(16'h3501);
    send(8'h01, 8'haa);
    rd_msg(16'h3501);
    send(8'h00, 8'h00);
    rd_msg(16'h3501);
    send(8'h36, 8'h00);
    rd_msg(16'h3600);
    send(8'h36, 8'h05);
    rd_msg(16'h3600);
    ev(2);
    send(8'h50, 8'h00);
    ev(2);
    send(8'h50, 8'h00);
    rd_msg(16'h0000);
    send(8'h50, 8'h01);
    rd_msg(16'h5001);
    ev(2);
    rd_msg(16'h0000);
  endtask : t_priority
  task automatic t_disable_recover;
    ev(3);
    rd_msg(16'hfe00);
    send(8'hff, 8'h00);
    ev(1);
    rd_msg(16'hfe00);
    ev(2);
    send(8'h40, 8'h00);
    ev(1);
    rd_msg(16'h0000);
    ev(4);
    chk({15'h0, auto_rec_on}, 16'h0000);
    send(8'h41, 8'h00);
    ev(1);
    rd_msg(16'h4100);
    ev(5);
    ev(1);
    rd_msg(16'h0000);
    msg_dev = 2'h2;
    send(8'h60, 8'h00);
    msg_dev = 2'h3;
    rd_msg(16'h0000);
  endtask : t_disable_recover
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {miscompares, n_checks, cycles} = '0;
    {rst_n, msg_valid, io_wr_valid} = 3'b000;
    {op_ack, heal_valid, host_valid, host_disable, cfg_auto_rec_wr} = 5'h00;
    {cfg_auto_rec_val, op_valid} = 2'b00;
    op_cmd = CMD_CLEAR;
    {msg_dev, heal_dev, host_dev} = 6'h3f;
    {msg_code, msg_data, io_wr_dev, io_wr_point, io_wr_data} = '0;
    eip_in_sel  = 32'h80400c21;
    eip_out_sel = 32'h0000050a;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk({11'h0, auto_rec_on, rsp_valid, out_upd_valid, disp_alert, disp_choice},
        16'h0010);
    t_inputs();
    t_outputs();
    t_display();
    t_priority();
    t_disable_recover();
    finish_test();
  end
endmodule : io_register_map_and_message_store_tb_top
